// [design/fdc_cmd_interp.v]
/*
  Command interpreter for configure, parameter dump and format track.
  Assumes command bytes arrive one per valid cycle from same-clock logic,
  and other-command and specify values are plain inputs; index is synchronised.
*/
`timescale 1ns/1ps
`include "fdc_cmd_consts.vh"

// Behaviour
// - configure: opcode, zero byte, mode byte, precomp byte; no result
// - hardware reset returns every configure field to default
// - implied-seek field drives seek-before-access output
// - fifo field 0 enables, default 1; soft reset keeps it if latched
// - poll-disable within 500 us of reset suppresses the reset interrupt
// - four-bit trigger level; soft reset clears it unless latched
// - eight-bit precomp start cylinder; soft reset clears it unless latched
// - dump: one opcode byte, then exactly ten result bytes
// - dump bytes one to four are present-track values of units 0-3
// - byte five step/motor-off, byte six motor-on and dma bit
// - byte seven sectors-per-track after format, else last sector number
// - byte eight: latch, 0, perp flags, spacing and write-gate selects
// - bytes nine and ten repeat configure mode byte and precomp cylinder
// - dumped parameters take defaults after reset unless latch protects them
// - format writing starts only after first index pulse
// - opcode bit six selects density encoding for the track
// - layout follows iso select and perpendicular selects
// - format: opcode, head/unit, size code, sectors, gap, filler
// - every sector data field filled with the filler byte
// - format ends on second index, interrupts, seven result bytes
// - unknown opcode gives single result byte 80h, no execution
// - hardware reset clears latch; clear latch lets soft reset restore
module fdc_cmd_interp #(
  parameter POLL_WINDOW = `POLL_WINDOW_CYC
) (
  // clock and resets
  input wire clk,
  input wire resetn,
  input wire soft_reset,
  // command bytes from host
  input wire cmd_valid,
  output wire cmd_ready,
  input wire [7:0] cmd_data,
  // result bytes to host
  output wire res_valid,
  input wire res_ready,
  output wire [7:0] res_data,
  // state kept by other commands
  input wire retention_latch,
  input wire [31:0] present_track_value,
  input wire [7:0] specify_step_motor_off,
  input wire [7:0] specify_motor_on_dma,
  input wire [3:0] perp_unit_flags,
  input wire perp_spacing_select,
  input wire perp_write_gate_select,
  input wire iso_format_select,
  input wire last_sector_number_strobe,
  input wire [7:0] last_sector_number,
  input wire [7:0] fmt_status0,
  input wire [7:0] fmt_status1,
  input wire [7:0] fmt_status2,
  // track side
  input wire index_pulse,
  // configuration outputs
  output reg implied_seek_enable,
  output reg fifo_disable,
  output reg poll_disable,
  output reg [3:0] fifo_trigger_level,
  output reg [7:0] precomp_start_cylinder,
  output reg poll_irq,
  // format execution
  output reg fmt_active,
  output reg fmt_writing,
  output reg fmt_density,
  output reg fmt_iso,
  output reg fmt_perp,
  output reg fmt_head,
  output reg [1:0] fmt_unit,
  output reg [7:0] fmt_size_code,
  output reg [7:0] fmt_gap,
  output reg [7:0] fmt_filler,
  output reg [7:0] fmt_id_byte,
  output reg fmt_id_strobe,
  output reg fmt_done_irq,
  output reg busy
);
  localparam ST_OPC = 3'd0;
  localparam ST_PARAM = 3'd1;
  localparam ST_FMT_WAIT = 3'd2;
  localparam ST_FMT_RUN = 3'd3;
  localparam ST_RESULT = 3'd4;

  localparam K_CFG = 2'd0;
  localparam K_FMT = 2'd1;
  localparam K_DUMP = 2'd2;
  localparam K_BAD = 2'd3;

  reg [2:0] state_r;
  reg cmd_ready_r;
  reg [1:0] kind_r;
  reg [2:0] pcount_r;
  reg [3:0] rindex_r;
  reg [7:0] mode_byte_r;
  reg [7:0] sectors_r;
  reg [7:0] sector_view_r;
  reg [7:0] sectors_left_r;
  reg [1:0] id_count_r;
  reg [22:0] poll_timer_r;
  reg poll_window_r;
  reg [2:0] index_sync_r;
  reg index_prev_r;
  wire index_level;
  wire index_rise;
  reg [7:0] res_byte;
  reg res_push;
  wire res_room;

  // index is a pin: three stages, change seen when last two agree
  assign index_level = index_sync_r[1] & index_sync_r[2];
  assign index_rise = index_level & ~index_prev_r;

  // ready for opcode and parameter bytes while idle or collecting, and for id bytes;
  // updated beside state_r so the port comes straight from a flop
  assign cmd_ready = cmd_ready_r;

  byte_skid_buffer #(
    .WIDTH(8)
  ) result_buf (
    .clk(clk),
    .resetn(resetn),
    .in_valid(res_push),
    .in_ready(res_room),
    .in_data(res_byte),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res_data)
  );

  always @*
  begin
    res_byte = 8'h00;
    case (kind_r)
      K_DUMP:
      begin
        case (rindex_r)
          4'd0: res_byte = present_track_value[7:0];
          4'd1: res_byte = present_track_value[15:8];
          4'd2: res_byte = present_track_value[23:16];
          4'd3: res_byte = present_track_value[31:24];
          4'd4: res_byte = specify_step_motor_off;
          4'd5: res_byte = specify_motor_on_dma;
          4'd6: res_byte = sector_view_r;
          4'd7: res_byte = {retention_latch, 1'b0, perp_unit_flags,
            perp_spacing_select, perp_write_gate_select};
          4'd8: res_byte = {1'b0, implied_seek_enable, fifo_disable,
            poll_disable, fifo_trigger_level};
          4'd9: res_byte = precomp_start_cylinder;
          default: res_byte = 8'h00;
        endcase
      end
      K_FMT:
      begin
        case (rindex_r)
          4'd0: res_byte = fmt_status0;
          4'd1: res_byte = fmt_status1;
          4'd2: res_byte = fmt_status2;
          default: res_byte = 8'h00;
        endcase
      end
      K_BAD: res_byte = `ST0_INVALID;
      default: res_byte = 8'h00;
    endcase
  end

  always @*
  begin
    res_push = (state_r == ST_RESULT) && res_room;
  end

  always @(posedge clk)
  begin
    if (!resetn)
    begin
      index_sync_r <= 3'b000;
      index_prev_r <= 1'b0;
    end
    else
    begin
      index_sync_r <= {index_sync_r[1:0], index_pulse};
      if (index_sync_r[1] == index_sync_r[2])
        index_prev_r <= index_level;
    end
  end

  always @(posedge clk)
  begin
    if (!resetn)
    begin
      // hardware reset defaults for every field
      implied_seek_enable <= `DEF_IMPLIED_SEEK;
      fifo_disable <= `DEF_FIFO_DISABLE;
      poll_disable <= `DEF_POLL_DISABLE;
      fifo_trigger_level <= `DEF_TRIGGER;
      precomp_start_cylinder <= `DEF_PRECOMP;
      sector_view_r <= 8'h00;
      poll_timer_r <= 23'd0;
      poll_window_r <= 1'b1;
      poll_irq <= 1'b0;
      state_r <= ST_OPC;
      cmd_ready_r <= 1'b1;
      kind_r <= K_CFG;
      pcount_r <= 3'd0;
      rindex_r <= 4'd0;
      mode_byte_r <= 8'h00;
      sectors_r <= 8'h00;
      sectors_left_r <= 8'h00;
      id_count_r <= 2'd0;
      fmt_active <= 1'b0;
      fmt_writing <= 1'b0;
      fmt_density <= 1'b0;
      fmt_iso <= 1'b0;
      fmt_perp <= 1'b0;
      fmt_head <= 1'b0;
      fmt_unit <= 2'd0;
      fmt_size_code <= 8'h00;
      fmt_gap <= 8'h00;
      fmt_filler <= 8'h00;
      fmt_id_byte <= 8'h00;
      fmt_id_strobe <= 1'b0;
      fmt_done_irq <= 1'b0;
      busy <= 1'b0;
    end
    else if (soft_reset)
    begin
      // latch clear lets soft reset restore fifo fields
      if (!retention_latch)
      begin
        fifo_disable <= `DEF_FIFO_DISABLE;
        fifo_trigger_level <= `DEF_TRIGGER;
        precomp_start_cylinder <= `DEF_PRECOMP;
      end
      implied_seek_enable <= `DEF_IMPLIED_SEEK;
      poll_disable <= `DEF_POLL_DISABLE;
      sector_view_r <= 8'h00;
      poll_timer_r <= 23'd0;
      poll_window_r <= 1'b1;
      poll_irq <= 1'b0;
      state_r <= ST_OPC;
      cmd_ready_r <= 1'b1;
      pcount_r <= 3'd0;
      fmt_active <= 1'b0;
      fmt_writing <= 1'b0;
      fmt_id_strobe <= 1'b0;
      fmt_done_irq <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      fmt_id_strobe <= 1'b0;
      fmt_done_irq <= 1'b0;
      // polling interrupt at window end unless disabled in time
      if (poll_window_r)
      begin
        if (poll_timer_r == POLL_WINDOW[22:0] - 23'd1)
        begin
          poll_window_r <= 1'b0;
          poll_irq <= ~poll_disable;
        end
        else
          poll_timer_r <= poll_timer_r + 23'd1;
      end
      // a newer read or write replaces the sector view
      if (last_sector_number_strobe)
        sector_view_r <= last_sector_number;
      case (state_r)
        ST_OPC:
        begin
          if (cmd_valid)
          begin
            busy <= 1'b1;
            pcount_r <= 3'd1;
            rindex_r <= 4'd0;
            // decode opcode and set expected byte count
            if (cmd_data == `OPC_CONFIGURE)
            begin
              kind_r <= K_CFG;
              state_r <= ST_PARAM;
            end
            else if (cmd_data == `OPC_DUMP)
            begin
              // no parameters, straight to ten results
              kind_r <= K_DUMP;
              state_r <= ST_RESULT;
              cmd_ready_r <= 1'b0;
            end
            else if ({cmd_data[7], cmd_data[5:0]} == `OPC_FORMAT_LOW)
            begin
              kind_r <= K_FMT;
              fmt_density <= cmd_data[`FMT_DENSITY_BIT];
              state_r <= ST_PARAM;
            end
            else
            begin
              kind_r <= K_BAD;
              state_r <= ST_RESULT;
              cmd_ready_r <= 1'b0;
            end
          end
          else
            busy <= 1'b0;
        end
        ST_PARAM:
        begin
          if (cmd_valid)
          begin
            pcount_r <= pcount_r + 3'd1;
            if (kind_r == K_CFG)
            begin
              // byte 2 mode fields, byte 3 precomp
              if (pcount_r == 3'd2)
                mode_byte_r <= cmd_data;
              if (pcount_r == `CFG_BYTES - 3'd1)
              begin
                implied_seek_enable <= mode_byte_r[6];
                fifo_disable <= mode_byte_r[5];
                poll_disable <= mode_byte_r[4];
                fifo_trigger_level <= mode_byte_r[3:0];
                precomp_start_cylinder <= cmd_data;
                // disable in time: the reset interrupt never fires
                if (poll_window_r && mode_byte_r[4])
                  poll_window_r <= 1'b0;
                state_r <= ST_OPC;
              end
            end
            else
            begin
              case (pcount_r)
                3'd1:
                begin
                  fmt_head <= cmd_data[`FMT_HEAD_BIT];
                  fmt_unit <= cmd_data[1:0];
                end
                3'd2: fmt_size_code <= cmd_data;
                3'd3: sectors_r <= cmd_data;
                3'd4: fmt_gap <= cmd_data;
                default:
                begin
                  // filler byte for every data field
                  fmt_filler <= cmd_data;
                  // layout selects latched for the track
                  fmt_iso <= iso_format_select;
                  fmt_perp <= perp_write_gate_select | perp_spacing_select;
                  fmt_active <= 1'b1;
                  sector_view_r <= sectors_r;
                  sectors_left_r <= sectors_r;
                  id_count_r <= 2'd0;
                  state_r <= ST_FMT_WAIT;
                  cmd_ready_r <= 1'b0;
                end
              endcase
            end
          end
        end
        ST_FMT_WAIT:
        begin
          // no writing before the index hole
          if (index_rise)
          begin
            fmt_writing <= 1'b1;
            state_r <= ST_FMT_RUN;
            cmd_ready_r <= 1'b1;
          end
        end
        ST_FMT_RUN:
        begin
          // four id bytes per sector from host
          if (cmd_valid && sectors_left_r != 8'h00)
          begin
            fmt_id_byte <= cmd_data;
            fmt_id_strobe <= 1'b1;
            id_count_r <= id_count_r + 2'd1;
            if (id_count_r == 2'd3)
              sectors_left_r <= sectors_left_r - 8'h01;
          end
          if (index_rise)
          begin
            fmt_writing <= 1'b0;
            fmt_active <= 1'b0;
            fmt_done_irq <= 1'b1;
            rindex_r <= 4'd0;
            state_r <= ST_RESULT;
            cmd_ready_r <= 1'b0;
          end
        end
        ST_RESULT:
        begin
          if (res_room)
          begin
            rindex_r <= rindex_r + 4'd1;
            if ((kind_r == K_BAD) ||
                (kind_r == K_DUMP && rindex_r == `DUMP_RESULT_BYTES - 4'd1) ||
                (kind_r == K_FMT && rindex_r == `FMT_RESULT_BYTES - 4'd1))
            begin
              state_r <= ST_OPC;
              cmd_ready_r <= 1'b1;
            end
          end
        end
        default:
        begin
          state_r <= ST_OPC;
          cmd_ready_r <= 1'b1;
        end
      endcase
    end
  end
endmodule

// [design/fdc_cmd_consts.vh]
/*
  Constants for the floppy command interpreter: opcodes, byte counts,
  field positions, reset defaults and timing counts.
  Assumes a 40 MHz core clock.
*/
`ifndef FDC_CMD_CONSTS_VH
`define FDC_CMD_CONSTS_VH
`define OPC_CONFIGURE 8'h13
`define OPC_DUMP 8'h0e
`define OPC_FORMAT_LOW 7'h0d
`define OPC_READ_LOW 5'h06
`define OPC_WRITE_LOW 6'h05
`define CFG_BYTES 3'h4
`define FMT_BYTES 3'h6
`define DUMP_RESULT_BYTES 4'ha
`define FMT_RESULT_BYTES 4'h7
`define ST0_INVALID 8'h80
`define FMT_DENSITY_BIT 6
`define FMT_HEAD_BIT 2
`define DEF_IMPLIED_SEEK 1'b0
`define DEF_FIFO_DISABLE 1'b1
`define DEF_POLL_DISABLE 1'b0
`define DEF_TRIGGER 4'h0
`define DEF_PRECOMP 8'h00
`define POLL_WINDOW_NS 500000
`define CLK_PERIOD_NS 25
`define POLL_WINDOW_CYC (`POLL_WINDOW_NS / `CLK_PERIOD_NS)
`define IDS_PER_SECTOR 3'h4
`endif

// [design/byte_skid_buffer.v]
/*
  Two-entry buffer with valid/ready on both sides; output data registered.
  Assumes a single clock and synchronous active-low reset.
*/
`timescale 1ns/1ps
module byte_skid_buffer #(
  parameter WIDTH = 8
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output reg out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] spare_r;
  reg spare_valid_r;

  assign in_ready = ~spare_valid_r;

  always @(posedge clk)
  begin
    if (!resetn)
    begin
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
      spare_valid_r <= 1'b0;
      spare_r <= {WIDTH{1'b0}};
    end
    else
    begin
      if (!out_valid || out_ready)
      begin
        if (spare_valid_r)
        begin
          out_valid <= 1'b1;
          out_data <= spare_r;
          spare_valid_r <= 1'b0;
        end
        else
        begin
          out_valid <= in_valid;
          if (in_valid)
            out_data <= in_data;
        end
      end
      else if (in_valid && !spare_valid_r)
      begin
        // head stalled: park the word instead of dropping it
        spare_r <= in_data;
        spare_valid_r <= 1'b1;
      end
    end
  end
endmodule

// [dv/fdc_cmd_interp_properties.sv]
/*
  Port assertions for the floppy command interpreter.
  Assumes one clock and a synchronous active-low hardware reset.
*/
`timescale 1ns/1ps
module fdc_cmd_interp_properties (
  // clock and resets
  input wire clk,
  input wire resetn,
  input wire soft_reset,
  // host side
  input wire cmd_valid,
  input wire cmd_ready,
  input wire [7:0] cmd_data,
  input wire res_valid,
  input wire res_ready,
  input wire [7:0] res_data,
  input wire busy,
  // configuration
  input wire retention_latch,
  input wire implied_seek_enable,
  input wire fifo_disable,
  input wire poll_disable,
  input wire poll_irq,
  input wire [3:0] fifo_trigger_level,
  input wire [7:0] precomp_start_cylinder,
  // format
  input wire index_pulse,
  input wire fmt_active,
  input wire fmt_writing,
  input wire fmt_done_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire tk = cmd_valid && cmd_ready;
  reg [7:0] d1_r;
  reg [7:0] d2_r;
  reg idx_r;
  // last two bytes seen and index seen during this format
  always @(posedge clk)
  begin
    d1_r <= cmd_data;
    d2_r <= d1_r;
    idx_r <= fmt_active && (idx_r || index_pulse);
  end
  property p_hw_def;
    $rose(resetn) |-> fifo_disable && !implied_seek_enable && !poll_disable && !poll_irq
      && fifo_trigger_level == 4'h0 && precomp_start_cylinder == 8'h00;
  endproperty
  a_hw_def: assert property (p_hw_def) else $error("config not default after reset");
  property p_soft_def;
    soft_reset && !retention_latch |=> fifo_disable && !implied_seek_enable
      && !poll_disable && fifo_trigger_level == 4'h0 && precomp_start_cylinder == 8'h00;
  endproperty
  a_soft_def: assert property (p_soft_def) else $error("soft reset left config");
  property p_soft_keep;
    soft_reset && retention_latch && !cmd_valid |=> $stable(fifo_disable)
      && $stable(fifo_trigger_level) && $stable(precomp_start_cylinder);
  endproperty
  a_soft_keep: assert property (p_soft_keep) else $error("latched config lost");
  property p_cfg;
    (tk && !busy && cmd_data == 8'h13 ##1 tk [*3]) |=> precomp_start_cylinder == d1_r
      && fifo_trigger_level == d2_r[3:0] && implied_seek_enable == d2_r[6]
      && fifo_disable == d2_r[5] && poll_disable == d2_r[4];
  endproperty
  a_cfg: assert property (p_cfg) else $error("configure fields not applied");
  property p_dump;
    tk && !busy && cmd_data == 8'h0e |-> ##2 res_valid;
  endproperty
  a_dump: assert property (p_dump) else $error("dump result late");
  property p_invalid;
    tk && !busy && cmd_data == 8'hff |-> ##2 res_valid && res_data == 8'h80;
  endproperty
  a_invalid: assert property (p_invalid) else $error("bad opcode status wrong");
  property p_hold;
    res_valid && !res_ready |=> res_valid && $stable(res_data);
  endproperty
  a_hold: assert property (p_hold) else $error("result byte dropped");
  property p_wr_idx;
    $rose(fmt_writing) |-> idx_r;
  endproperty
  a_wr_idx: assert property (p_wr_idx) else $error("format wrote before index");
  property p_done;
    fmt_done_irq |=> !fmt_done_irq ##[0:3] res_valid;
  endproperty
  a_done: assert property (p_done) else $error("format end irq or result wrong");
endmodule

bind fdc_cmd_interp fdc_cmd_interp_properties fdc_cmd_interp_properties_i (
  .clk, .resetn, .soft_reset, .cmd_valid, .cmd_ready, .cmd_data, .res_valid,
  .res_ready, .res_data, .busy, .retention_latch, .implied_seek_enable,
  .fifo_disable, .poll_disable, .poll_irq, .fifo_trigger_level,
  .precomp_start_cylinder, .index_pulse, .fmt_active, .fmt_writing, .fmt_done_irq);

// [dv/fdc_host_model.sv]
/*
  Host model: writes command and id bytes, reads result bytes.
  Assumes one clock; drives just after rising edges, samples mid-cycle.
*/
`timescale 1ns/1ps
module fdc_host_model (
  // clock
  input wire clk,
  // command side
  output logic cmd_valid,
  output logic [7:0] cmd_data,
  input wire cmd_ready,
  // result side
  input wire res_valid,
  output logic res_ready,
  input wire [7:0] res_data
);
  initial
  begin
    cmd_valid = 1'h0;
    cmd_data = 8'h00;
    res_ready = 1'h0;
  end
  task put(input [7:0] b);
    reg r;
    begin
      cmd_valid <= 1'h1;
      cmd_data <= b;
      r = 1'h0;
      while (!r)
      begin
        @(negedge clk);
        r = (cmd_ready === 1'h1);
        @(posedge clk);
      end
    end
  endtask
  task get(output [7:0] b, input integer stall);
    reg v;
    begin
      if (stall > 0)
        res_ready <= 1'h0;
      repeat (stall) @(posedge clk);
      res_ready <= 1'h1;
      v = 1'h0;
      while (!v)
      begin
        @(negedge clk);
        v = (res_valid === 1'h1);
        b = res_data;
        @(posedge clk);
      end
    end
  endtask
  // released data shows garbage, not the last byte
  task rel;
    begin
      cmd_valid <= 1'h0;
      cmd_data <= ~cmd_data;
    end
  endtask
  task done;
    res_ready <= 1'h0;
  endtask
endmodule

// [dv/tb_fdc_cmd_interp.sv]
/*
  Testbench for the floppy command interpreter.
  Assumes the host model and the bound property checker.
*/
`timescale 1ns/1ps
module tb_fdc_cmd_interp;
  // stimulus
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic soft_reset = 1'h0;
  logic retention_latch = 1'h1;
  logic [31:0] present_track_value = 32'h4433_2211;
  logic [7:0] spa = 8'hd7;
  logic [7:0] spb = 8'h4b;
  logic [3:0] perp_unit_flags = 4'ha;
  logic spc = 1'h1;
  logic wg = 1'h0;
  logic lsn_stb = 1'h0;
  logic [7:0] lsn = 8'h12;
  logic index_pulse = 1'h0;
  logic iso_sel = 1'h0;
  logic [7:0] st0 = 8'h00;
  logic [7:0] st1 = 8'h00;
  logic [7:0] st2 = 8'h00;
  // observed
  wire cmd_valid, cmd_ready, res_valid, res_ready, busy, poll_irq;
  wire [7:0] cmd_data, res_data, fmt_size_code, fmt_gap, fmt_filler, fmt_id_byte;
  wire implied_seek_enable, fifo_disable, poll_disable, fmt_active, fmt_writing;
  wire fmt_density, fmt_iso, fmt_perp, fmt_head, fmt_id_strobe, fmt_done_irq;
  wire [1:0] fmt_unit;
  wire [3:0] fifo_trigger_level;
  wire [7:0] precomp_start_cylinder;
  integer miscompares = 0;
  integer num_checks = 0;
  integer ids = 0;
  integer dones = 0;
  reg [7:0] id_last;
  reg [7:0] b;
  integer i;

  // short window keeps the poll wait cheap
  fdc_cmd_interp #(.POLL_WINDOW(50)) fdc_cmd_interp_i (
    .clk, .resetn, .soft_reset, .cmd_valid, .cmd_ready, .cmd_data, .res_valid,
    .res_ready, .res_data, .retention_latch, .present_track_value,
    .specify_step_motor_off(spa), .specify_motor_on_dma(spb), .perp_unit_flags,
    .perp_spacing_select(spc), .perp_write_gate_select(wg), .iso_format_select(iso_sel),
    .last_sector_number_strobe(lsn_stb), .last_sector_number(lsn),
    .fmt_status0(st0), .fmt_status1(st1), .fmt_status2(st2), .index_pulse,
    .implied_seek_enable, .fifo_disable, .poll_disable, .fifo_trigger_level,
    .precomp_start_cylinder, .poll_irq, .fmt_active, .fmt_writing, .fmt_density,
    .fmt_iso, .fmt_perp, .fmt_head, .fmt_unit, .fmt_size_code, .fmt_gap,
    .fmt_filler, .fmt_id_byte, .fmt_id_strobe, .fmt_done_irq, .busy);
  fdc_host_model host_i (
    .clk, .cmd_valid, .cmd_data, .cmd_ready, .res_valid, .res_ready, .res_data);

  initial
  begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (fmt_id_strobe === 1'h1)
    begin
      ids <= ids + 1;
      id_last <= fmt_id_byte;
    end
    if (fmt_done_irq === 1'h1)
      dones <= dones + 1;
  end

  task chk(input string what, input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task cfg(input [7:0] m, input [7:0] p);
    begin
      host_i.put(8'h13);
      host_i.put(8'h00);
      host_i.put(m);
      host_i.put(p);
      host_i.rel;
      repeat (2) @(posedge clk);
      chk("seek", implied_seek_enable, m[6]);
      chk("fifo", fifo_disable, m[5]);
      chk("poll", poll_disable, m[4]);
      chk("trigger", fifo_trigger_level, m[3:0]);
      chk("precomp", precomp_start_cylinder, p);
    end
  endtask
  task dump(input [7:0] sec, input [7:0] m, input [7:0] p);
    reg [7:0] e [0:9];
    begin
      for (i = 0; i < 4; i = i + 1)
        e[i] = present_track_value[8*i +: 8];
      e[4] = spa;
      e[5] = spb;
      e[6] = sec;
      e[7] = {retention_latch, 1'h0, perp_unit_flags, spc, wg};
      e[8] = m;
      e[9] = p;
      host_i.put(8'h0e);
      host_i.rel;
      for (i = 0; i < 10; i = i + 1)
      begin
        host_i.get(b, i % 3);
        chk("dump byte", b, e[i]);
      end
      host_i.done;
      repeat (3) @(posedge clk);
      chk("dump length", res_valid, 1'h0);
      chk("dump idle", busy, 1'h0);
    end
  endtask
  task index_mark;
    begin
      index_pulse <= 1'h1;
      repeat (3) @(posedge clk);
      index_pulse <= 1'h0;
      repeat (6) @(posedge clk);
    end
  endtask
  task t_invalid;
    begin
      host_i.put(8'hff);
      host_i.rel;
      host_i.get(b, 1);
      host_i.done;
      chk("bad opcode", b, 8'h80);
      repeat (3) @(posedge clk);
      chk("bad length", res_valid, 1'h0);
    end
  endtask
  task t_format;
    begin
      iso_sel <= 1'h1;
      host_i.put(8'h4d);
      host_i.put(8'h06);
      host_i.put(8'h02);
      host_i.put(8'h02);
      host_i.put(8'h54);
      host_i.put(8'he5);
      host_i.rel;
      repeat (4) @(posedge clk);
      chk("wait index", {fmt_active, fmt_writing}, 2'h2);
      chk("density", fmt_density, 1'h1);
      chk("layout", {fmt_iso, fmt_perp}, 2'h3);
      chk("unit", {fmt_head, fmt_unit, fmt_size_code, fmt_gap}, 19'h6_0254);
      chk("filler", fmt_filler, 8'he5);
      chk("busy", busy, 1'h1);
      index_mark;
      chk("writing", fmt_writing, 1'h1);
      // two ids beyond the sector count must be dropped
      for (i = 0; i < 10; i = i + 1)
        host_i.put(i[7:0]);
      host_i.rel;
      repeat (2) @(posedge clk);
      chk("id count", ids, 8);
      chk("id last", id_last, 8'h07);
      // execution side reports its status before the track ends
      st0 <= 8'h46;
      st1 <= 8'h01;
      st2 <= 8'h20;
      index_mark;
      for (i = 0; i < 7; i = i + 1)
      begin
        host_i.get(b, i % 2);
        chk("format result", b, i == 0 ? 8'h46 : i == 1 ? 8'h01 : i == 2 ? 8'h20 : 8'h00);
      end
      host_i.done;
      chk("format irq", dones, 1);
      dump(8'h02, 8'h5a, 8'hc3);
    end
  endtask
  task t_soft;
    begin
      soft_reset <= 1'h1;
      @(posedge clk);
      soft_reset <= 0;
      @(posedge clk);
      chk("latched", {fifo_disable, fifo_trigger_level, precomp_start_cylinder}, 13'h0ac3);
      chk("soft seek poll", {implied_seek_enable, poll_disable}, 2'h0);
      retention_latch <= 1'h0;
      soft_reset <= 1'h1;
      @(posedge clk);
      soft_reset <= 0;
      @(posedge clk);
      chk("unlatched", {fifo_disable, fifo_trigger_level, precomp_start_cylinder}, 13'h1000);
      present_track_value <= 32'h0807_0605;
      spa <= 8'h31;
      spb <= 8'hc2;
      perp_unit_flags <= 4'h5;
      spc <= 1'h0;
      wg <= 1'h1;
      lsn <= 8'h09;
      lsn_stb <= 1'h1;
      @(posedge clk);
      lsn_stb <= 1'h0;
      dump(8'h09, 8'h20, 8'h00);
    end
  endtask
  task t_hard;
    begin
      resetn <= 1'h0;
      repeat (16) @(posedge clk);
      resetn <= 1'h1;
      repeat (60) @(posedge clk);
      chk("poll irq", poll_irq, 1'h1);
      chk("hw default", {implied_seek_enable, fifo_disable, poll_disable}, 3'h2);
      chk("hw trigger", {fifo_trigger_level, precomp_start_cylinder}, 12'h000);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    resetn <= 1'h1;
    // mid-level trigger; poll disabled inside the window
    cfg(8'h5a, 8'hc3);
    repeat (60) @(posedge clk);
    chk("poll quiet", poll_irq, 1'h0);
    lsn_stb <= 1'h1;
    @(posedge clk);
    lsn_stb <= 1'h0;
    dump(8'h12, 8'h5a, 8'hc3);
    t_invalid;
    t_format;
    retention_latch <= 1'h1;
    t_soft;
    t_hard;
    summarize;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares = miscompares + 1;
    summarize;
  end
endmodule
